// ===== logic/ccpu_unit.sv
// Capture/compare/PWM unit with an 8-bit register port.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module ccpu_unit #(
    parameter int PRESCALE_WIDTH = 4
)(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    input wire logic [15:0] timer_zero_count_in,
    input wire logic [15:0] timer_one_count_in,
    input wire logic routed_input_pin_in,
    input wire logic comparator_one_out_in,
    input wire logic comparator_two_out_in,
    input wire logic numeric_oscillator_out_in,
    input wire logic pin_change_event_in,
    input wire logic logic_cell_one_out_in,
    input wire logic logic_cell_two_out_in,
    input wire logic pin_direction_in,
    input wire logic port_latch_in,
    input wire logic [7:0] base_counter_in,
    input wire logic [1:0] base_fraction_in,
    input wire logic [7:0] period_limit_in,
    input wire logic base_tick_in,
    input wire logic adc_trigger_select_in,
    input wire logic sleep_in,
    output logic [7:0] rd_data_out,
    output logic unit_out,
    output logic adc_trigger_out,
    output logic timer_one_reset_out,
    output logic wake_out,
    output logic unit_event_flag_out
);
    // ==========================================================
    // Parameter check
    generate
        if (PRESCALE_WIDTH < 4)
        begin : g_bad_width
            $error("Prescale counter must hold at least sixteen counts.");
        end
    endgenerate

    // ==========================================================
    // State
    logic [7:0] ctl_r, ctl_nxt;
    logic [3:0] capsel_r, capsel_nxt;
    logic [15:0] val_r, val_nxt;
    logic flag_r, flag_nxt, ien_r, ien_nxt, out_r, out_nxt;
    logic [PRESCALE_WIDTH-1:0] presc_r, presc_nxt;
    logic [7:0] src_vec, src_s1_r, src_s2_r;
    logic src_prev_r, src_mux;
    logic match_prev_r, pend_r, pend_nxt, adc_r, adc_nxt, trst_r, trst_nxt;
    logic pulse_r, pulse_nxt, wake_r, wake_nxt;
    logic [9:0] duty_buf_r, duty_buf_nxt, width, timebase;
    logic [7:0] rd_r, rd_nxt;
    logic [3:0] mode;
    logic is_cap, is_cmp, is_pwm, rise, fall, cap_event, cmp_eq, cmp_hit, reload;
    logic [15:0] cap_time;

    // ==========================================================
    // Capture source synchroniser and select
    // Every source passes two flip-flops before the select reads it.
    assign src_vec = {port_latch_in, logic_cell_two_out_in, logic_cell_one_out_in,
                      pin_change_event_in, numeric_oscillator_out_in, comparator_two_out_in,
                      comparator_one_out_in, routed_input_pin_in};

    always_comb
    begin
        case (capsel_r[2:0])
            ccpu_pkg::SRC_PIN: src_mux = pin_direction_in ? src_s2_r[0] : src_s2_r[7];
            ccpu_pkg::SRC_CMP1: src_mux = src_s2_r[1];
            ccpu_pkg::SRC_CMP2: src_mux = src_s2_r[2];
            ccpu_pkg::SRC_OSC: src_mux = src_s2_r[3];
            ccpu_pkg::SRC_PIN_CHANGE: src_mux = src_s2_r[4];
            ccpu_pkg::SRC_CELL1: src_mux = src_s2_r[5];
            ccpu_pkg::SRC_CELL2: src_mux = src_s2_r[6];
            default: src_mux = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            src_s1_r <= 8'h00;
            src_s2_r <= 8'h00;
            src_prev_r <= 1'b0;
            match_prev_r <= 1'b0;
        end
        else
        begin
            src_s1_r <= src_vec;
            src_s2_r <= src_s1_r;
            src_prev_r <= src_mux;
            match_prev_r <= cmp_eq;
        end
    end

    // ==========================================================
    // Mode decode and events
    always_comb
    begin
        mode = ctl_r[3:0];
        is_cap = ctl_r[ccpu_pkg::CTL_EN_BIT] && (mode >= ccpu_pkg::MODE_CAP_EDGE)
                 && (mode <= ccpu_pkg::MODE_CAP_RISE16);
        is_cmp = ctl_r[ccpu_pkg::CTL_EN_BIT] && ((mode == ccpu_pkg::MODE_TOGGLE_CLR)
                 || (mode == ccpu_pkg::MODE_TOGGLE) || ((mode >= ccpu_pkg::MODE_SET)
                 && (mode <= ccpu_pkg::MODE_PULSE_CLR)));
        is_pwm = ctl_r[ccpu_pkg::CTL_EN_BIT] && (mode == ccpu_pkg::MODE_PWM);
        rise = src_mux && !src_prev_r;
        fall = !src_mux && src_prev_r;
        case (mode)
            ccpu_pkg::MODE_CAP_EDGE: cap_event = rise || fall;
            ccpu_pkg::MODE_CAP_FALL: cap_event = fall;
            ccpu_pkg::MODE_CAP_RISE: cap_event = rise;
            ccpu_pkg::MODE_CAP_RISE4: cap_event = rise
                && (presc_r[3:0] == ccpu_pkg::PRESCALE_4_LAST);
            ccpu_pkg::MODE_CAP_RISE16: cap_event = rise
                && (presc_r[3:0] == ccpu_pkg::PRESCALE_16_LAST);
            default: cap_event = 1'b0;
        endcase
        cap_event = cap_event && is_cap;
        cap_time = capsel_r[ccpu_pkg::CAP_TIMER_ZERO_BIT] ? timer_zero_count_in
                                                          : timer_one_count_in;
        cmp_eq = (val_r == timer_one_count_in);
        cmp_hit = is_cmp && cmp_eq && !match_prev_r;
        width = ctl_r[ccpu_pkg::CTL_FMT_BIT] ? val_r[15:6]
                                             : {val_r[9:8], val_r[7:0]};
        timebase = {base_counter_in, base_fraction_in};
        reload = is_pwm && base_tick_in && (base_counter_in == period_limit_in);
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        ctl_nxt = ctl_r;
        capsel_nxt = capsel_r;
        val_nxt = val_r;
        ien_nxt = ien_r;
        flag_nxt = flag_r;
        out_nxt = out_r;
        presc_nxt = presc_r;
        duty_buf_nxt = duty_buf_r;
        pulse_nxt = 1'b0;
        rd_nxt = 8'h00;
        if (wr_strobe_in)
        begin
            case (addr_in)
                ccpu_pkg::ADDR_CONTROL: ctl_nxt = {wr_data_in[7], 2'b00, wr_data_in[4:0]};
                ccpu_pkg::ADDR_CAPSEL: capsel_nxt = wr_data_in[3:0];
                ccpu_pkg::ADDR_VAL_LOW: val_nxt[7:0] = wr_data_in;
                ccpu_pkg::ADDR_VAL_HIGH: val_nxt[15:8] = wr_data_in;
                ccpu_pkg::ADDR_FLAG:
                begin
                    flag_nxt = wr_data_in[ccpu_pkg::FLAG_BIT];
                    ien_nxt = wr_data_in[ccpu_pkg::ENABLE_BIT];
                end
                default: ;
            endcase
        end
        if (rd_strobe_in)
        begin
            case (addr_in)
                ccpu_pkg::ADDR_CONTROL: rd_nxt = {ctl_r[7:6], out_r, ctl_r[4:0]};
                ccpu_pkg::ADDR_CAPSEL: rd_nxt = {4'h0, capsel_r};
                ccpu_pkg::ADDR_VAL_LOW: rd_nxt = val_r[7:0];
                ccpu_pkg::ADDR_VAL_HIGH: rd_nxt = val_r[15:8];
                ccpu_pkg::ADDR_FLAG: rd_nxt = {6'h00, ien_r, flag_r};
                default: rd_nxt = 8'h00;
            endcase
        end
        if (!is_cap)
            presc_nxt = '0;
        else if (rise && ((mode == ccpu_pkg::MODE_CAP_RISE4)
                 || (mode == ccpu_pkg::MODE_CAP_RISE16)))
            presc_nxt = cap_event ? '0 : presc_r + 1'b1;
        if (cap_event)
            val_nxt = cap_time;
        if (cap_event || cmp_hit)
            flag_nxt = 1'b1;
        if (cmp_hit)
        begin
            case (mode)
                ccpu_pkg::MODE_TOGGLE_CLR, ccpu_pkg::MODE_TOGGLE: out_nxt = !out_r;
                ccpu_pkg::MODE_SET: out_nxt = 1'b1;
                ccpu_pkg::MODE_CLEAR: out_nxt = 1'b0;
                default:
                begin
                    out_nxt = 1'b1;
                    pulse_nxt = 1'b1;
                end
            endcase
        end
        else if (pulse_r)
            out_nxt = 1'b0;
        if (reload)
        begin
            duty_buf_nxt = width;
            out_nxt = (width != 10'h000);
        end
        else if (is_pwm && (timebase == duty_buf_r))
            out_nxt = 1'b0;
        if (ctl_r == 8'h00)
            out_nxt = 1'b0;
        adc_nxt = cmp_hit && adc_trigger_select_in;
        pend_nxt = cmp_hit && ((mode == ccpu_pkg::MODE_TOGGLE_CLR)
                   || (mode == ccpu_pkg::MODE_PULSE_CLR));
        trst_nxt = pend_r && cmp_eq;
        wake_nxt = sleep_in && flag_nxt && ien_r;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctl_r <= ccpu_pkg::CONTROL_RESET;
            capsel_r <= ccpu_pkg::CAPSEL_RESET;
            val_r <= ccpu_pkg::VALUE_RESET;
            ien_r <= 1'b0;
            flag_r <= 1'b0;
            out_r <= 1'b0;
            presc_r <= '0;
            duty_buf_r <= 10'h000;
            pulse_r <= 1'b0;
            adc_r <= 1'b0;
            pend_r <= 1'b0;
            trst_r <= 1'b0;
            wake_r <= 1'b0;
            rd_r <= 8'h00;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            capsel_r <= capsel_nxt;
            val_r <= val_nxt;
            ien_r <= ien_nxt;
            flag_r <= flag_nxt;
            out_r <= out_nxt;
            presc_r <= presc_nxt;
            duty_buf_r <= duty_buf_nxt;
            pulse_r <= pulse_nxt;
            adc_r <= adc_nxt;
            pend_r <= pend_nxt;
            trst_r <= trst_nxt;
            wake_r <= wake_nxt;
            rd_r <= rd_nxt;
        end
    end

    assign rd_data_out = rd_r;
    assign unit_out = out_r;
    assign adc_trigger_out = adc_r;
    assign timer_one_reset_out = trst_r;
    assign wake_out = wake_r;
    assign unit_event_flag_out = flag_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);

    cap_store_a: assert property (cap_event |=> val_r == $past(cap_time))
        else $error("Captured value differs from the timer count.");
    cap_div4_a: assert property ((cap_event && mode == ccpu_pkg::MODE_CAP_RISE4)
        |-> rise && presc_r == 4'h3 ##1 presc_r == 4'h0)
        else $error("Fourth-edge capture at wrong count.");
    flag_set_a: assert property ((cap_event || cmp_hit) |=> unit_event_flag_out)
        else $error("Event flag not set by an event.");
    presc_clear_a: assert property (!is_cap |=> presc_r == '0)
        else $error("Prescaler not cleared outside capture.");
    toggle_out_a: assert property ((cmp_hit && mode == ccpu_pkg::MODE_TOGGLE)
        |=> unit_out != $past(unit_out))
        else $error("Output did not toggle on match.");
    adc_trig_a: assert property ((cmp_hit && adc_trigger_select_in)
        |=> adc_trigger_out ##1 !adc_trigger_out)
        else $error("Conversion trigger not one cycle after match.");
    zero_ctl_a: assert property (ctl_r == 8'h00 |=> !unit_out)
        else $error("Output latch not low with zero control.");
    timer_reset_a: assert property (timer_one_reset_out |-> $past(pend_r)
        && $past(val_r) == $past(timer_one_count_in))
        else $error("Timer reset issued after value change.");
    pwm_reload_a: assert property (reload |=> duty_buf_r == $past(width)
        && unit_out == ($past(width) != 10'h000))
        else $error("Width not buffered or output wrong at period end.");
    pwm_clear_a: assert property ((is_pwm && !reload && timebase == duty_buf_r
        && ctl_r != 8'h00) |=> !unit_out)
        else $error("Output not cleared at width match.");
endmodule

// ===== logic/ccpu_pkg.sv
// Register map, field positions, mode codes and reset values of the capture/compare/PWM unit.
package ccpu_pkg;
    // ==========================================================
    // Register offsets
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_CAPSEL = 3'h1;
    localparam logic [2:0] ADDR_VAL_LOW = 3'h2;
    localparam logic [2:0] ADDR_VAL_HIGH = 3'h3;
    localparam logic [2:0] ADDR_FLAG = 3'h4;
    // ==========================================================
    // Field positions
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_OUT_BIT = 5;
    localparam int CTL_FMT_BIT = 4;
    localparam int CAP_TIMER_ZERO_BIT = 3;
    localparam int FLAG_BIT = 0;
    localparam int ENABLE_BIT = 1;
    // ==========================================================
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [3:0] CAPSEL_RESET = 4'h0;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    // ==========================================================
    // Mode codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE_CLR = 4'h1;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_EDGE = 4'h3;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_SET = 4'h8;
    localparam logic [3:0] MODE_CLEAR = 4'h9;
    localparam logic [3:0] MODE_PULSE = 4'hA;
    localparam logic [3:0] MODE_PULSE_CLR = 4'hB;
    localparam logic [3:0] MODE_PWM = 4'hF;
    // ==========================================================
    // Capture source codes and prescaler terminal counts
    localparam logic [2:0] SRC_PIN = 3'h0;
    localparam logic [2:0] SRC_CMP1 = 3'h1;
    localparam logic [2:0] SRC_CMP2 = 3'h2;
    localparam logic [2:0] SRC_OSC = 3'h3;
    localparam logic [2:0] SRC_PIN_CHANGE = 3'h4;
    localparam logic [2:0] SRC_CELL1 = 3'h5;
    localparam logic [2:0] SRC_CELL2 = 3'h6;
    localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
endpackage

// ===== test/ccpu_far_side.sv
// Timers and period time base that feed the capture/compare/PWM unit.
`timescale 1ns/10ps
module ccpu_far_side (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic t1_run_in,
    input wire logic t1_load_in,
    input wire logic [15:0] t1_load_val_in,
    input wire logic t1_clear_in,
    input wire logic base_run_in,
    input wire logic [7:0] period_limit_in,
    output logic [15:0] timer_one_count_out,
    output logic [15:0] timer_zero_count_out,
    output logic [7:0] base_counter_out,
    output logic [1:0] base_fraction_out,
    output logic base_tick_out
);
    // ==========================================================
    // Counters
    logic [15:0] t1_r;
    logic [7:0] base_r;
    logic [1:0] frac_r;
    assign timer_one_count_out = t1_r;
    assign timer_zero_count_out = {t1_r[7:0], t1_r[15:8]};
    assign base_counter_out = base_r;
    assign base_fraction_out = frac_r;
    assign base_tick_out = base_run_in && (frac_r == 2'h3);
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            t1_r <= 16'h0000;
            base_r <= 8'h00;
            frac_r <= 2'h0;
        end
        else
        begin
            frac_r <= frac_r + 2'h1;
            if (t1_clear_in)
                t1_r <= 16'h0000;
            else if (t1_load_in)
                t1_r <= t1_load_val_in;
            else if (t1_run_in && frac_r == 2'h3)
                t1_r <= t1_r + 16'h0001;
            if (base_tick_out)
                base_r <= (base_r == period_limit_in) ? 8'h00 : base_r + 8'h01;
        end
    end
endmodule

// ===== test/tb.sv
// Self-checking testbench of the capture/compare/PWM unit.
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, plim = 8'h07, rdata;
    logic [6:0] src = 7'h00;
    logic pin_dir = 1'b1, latch = 1'b0, adc_sel = 1'b1, sleep = 1'b0;
    logic t1_run = 1'b0, t1_load = 1'b0, base_run = 1'b0;
    logic [15:0] t1_val = 16'h0000, t1, t0;
    logic [7:0] bcnt;
    logic [1:0] bfrac;
    logic btick, uout, adc, t1rst, wake, flag;
    logic [7:0] cmodes [6] = '{8'h88, 8'h82, 8'h81, 8'h89, 8'h8A, 8'h8B};
    logic cexp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    int n_mismatch = 0, n_compared = 0, i, h10, h20, h0;
    ccpu_far_side ccpu_far_side_inst (.core_clk_in(clk), .nrst_in(nrst), .t1_run_in(t1_run),
        .t1_load_in(t1_load), .t1_load_val_in(t1_val), .t1_clear_in(t1rst),
        .base_run_in(base_run), .period_limit_in(plim), .timer_one_count_out(t1),
        .timer_zero_count_out(t0), .base_counter_out(bcnt), .base_fraction_out(bfrac),
        .base_tick_out(btick));
    ccpu_unit ccpu_unit_inst (.core_clk_in(clk), .nrst_in(nrst), .addr_in(addr),
        .wr_data_in(wdata), .wr_strobe_in(wr), .rd_strobe_in(rd), .timer_zero_count_in(t0),
        .timer_one_count_in(t1), .routed_input_pin_in(src[0]), .comparator_one_out_in(src[1]),
        .comparator_two_out_in(src[2]), .numeric_oscillator_out_in(src[3]),
        .pin_change_event_in(src[4]), .logic_cell_one_out_in(src[5]),
        .logic_cell_two_out_in(src[6]), .pin_direction_in(pin_dir), .port_latch_in(latch),
        .base_counter_in(bcnt), .base_fraction_in(bfrac), .period_limit_in(plim),
        .base_tick_in(btick), .adc_trigger_select_in(adc_sel), .sleep_in(sleep),
        .rd_data_out(rdata), .unit_out(uout), .adc_trigger_out(adc),
        .timer_one_reset_out(t1rst), .wake_out(wake), .unit_event_flag_out(flag));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // ==========================================================
    // Access tasks
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask
    task automatic wait_sig(input int which, input logic lvl);
        logic [4:0] s;
        for (int k = 0; k < 600; k++)
        begin
            @(posedge clk);
            #1;
            s = {wake, t1rst, adc, uout, flag};
            if (s[which] === lvl)
                return;
        end
        n_mismatch++;
        tally_and_finish();
    endtask
    task automatic setmode(input logic [7:0] m);
        wr_reg(3'h0, 8'h00);
        wr_reg(3'h0, m);
        wr_reg(3'h4, 8'h00);
    endtask
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clk);
            src[0] <= 1'b1;
            repeat (6) @(posedge clk);
            src[0] <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask
    task automatic t1_set(input logic [15:0] v, input logic run);
        @(posedge clk);
        t1_val <= v;
        t1_load <= 1'b1;
        t1_run <= run;
        @(posedge clk);
        t1_load <= 1'b0;
    endtask
    task automatic count_hi(output int h);
        wait_sig(1, 1'b0);
        wait_sig(1, 1'b1);
        h = 0;
        repeat (32)
        begin
            @(posedge clk);
            #1;
            h += int'(uout);
        end
    endtask
    // ==========================================================
    // Scenarios
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(ccpu_pkg::ADDR_CONTROL, ccpu_pkg::CONTROL_RESET);
        rd_chk(ccpu_pkg::ADDR_VAL_HIGH, 8'h00);
        rd_chk(3'h5, 8'h00);
        t1_set(16'h1234, 1'b0);
        setmode(8'h85);
        pulses(1);
        rd_chk(ccpu_pkg::ADDR_VAL_LOW, 8'h34);
        rd_chk(ccpu_pkg::ADDR_VAL_HIGH, 8'h12);
        rd_chk(ccpu_pkg::ADDR_FLAG, 8'h01);
        wr_reg(ccpu_pkg::ADDR_FLAG, 8'h00);
        rd_chk(ccpu_pkg::ADDR_FLAG, 8'h00);
        t1_set(16'h1111, 1'b0);
        pulses(1);
        t1_set(16'h5678, 1'b0);
        pulses(1);
        rd_chk(ccpu_pkg::ADDR_VAL_LOW, 8'h78);
        wr_reg(ccpu_pkg::ADDR_CAPSEL, 8'h08);
        pulses(1);
        rd_chk(ccpu_pkg::ADDR_VAL_LOW, 8'h56);
        wr_reg(ccpu_pkg::ADDR_CAPSEL, 8'h00);
        @(posedge clk);
        src[0] <= 1'b1;
        setmode(8'h84);
        src[0] <= 1'b0;
        wait_sig(0, 1'b1);
        setmode(8'h83);
        src[0] <= 1'b1;
        wait_sig(0, 1'b1);
        setmode(8'h83);
        src[0] <= 1'b0;
        wait_sig(0, 1'b1);
        setmode(8'h86);
        pulses(3);
        rd_chk(ccpu_pkg::ADDR_FLAG, 8'h00);
        pulses(1);
        rd_chk(ccpu_pkg::ADDR_FLAG, 8'h01);
        setmode(8'h86);
        pulses(2);
        setmode(8'h86);
        pulses(3);
        rd_chk(ccpu_pkg::ADDR_FLAG, 8'h00);
        pulses(1);
        rd_chk(ccpu_pkg::ADDR_FLAG, 8'h01);
        setmode(8'h87);
        pulses(15);
        rd_chk(ccpu_pkg::ADDR_FLAG, 8'h00);
        pulses(1);
        rd_chk(ccpu_pkg::ADDR_FLAG, 8'h01);
        for (i = 0; i < 7; i++)
        begin
            wr_reg(ccpu_pkg::ADDR_CAPSEL, 8'(i));
            setmode(8'h85);
            src[(i + 1) % 7] <= 1'b1;
            repeat (8) @(posedge clk);
            rd_chk(ccpu_pkg::ADDR_FLAG, 8'h00);
            src[i] <= 1'b1;
            wait_sig(0, 1'b1);
            src <= 7'h00;
        end
        wr_reg(ccpu_pkg::ADDR_CAPSEL, 8'h00);
        pin_dir <= 1'b0;
        setmode(8'h85);
        latch <= 1'b1;
        wait_sig(0, 1'b1);
        pin_dir <= 1'b1;
        wr_reg(ccpu_pkg::ADDR_VAL_LOW, 8'h40);
        wr_reg(ccpu_pkg::ADDR_VAL_HIGH, 8'h00);
        for (i = 0; i < 6; i++)
        begin
            t1_set(16'h0030, 1'b0);
            adc_sel <= (i != 1);
            wr_reg(ccpu_pkg::ADDR_FLAG, 8'h00);
            wr_reg(ccpu_pkg::ADDR_CONTROL, cmodes[i]);
            t1_set(16'h0030, 1'b1);
            wait_sig(0, 1'b1);
            `CHK(adc, (i != 1))
            `CHK(uout, cexp[i])
            @(posedge clk);
            #1;
            if (i > 3)
                `CHK(uout, 1'b0)
            `CHK(t1rst, (i == 2 || i == 5))
        end
        t1_set(16'h0030, 1'b0);
        wr_reg(ccpu_pkg::ADDR_CONTROL, 8'h88);
        t1_set(16'h0030, 1'b1);
        wait_sig(1, 1'b1);
        wr_reg(ccpu_pkg::ADDR_CONTROL, 8'h00);
        @(posedge clk);
        #1;
        `CHK(uout, 1'b0)
        t1_run <= 1'b0;
        sleep <= 1'b1;
        wr_reg(ccpu_pkg::ADDR_FLAG, 8'h03);
        wait_sig(4, 1'b1);
        wr_reg(ccpu_pkg::ADDR_FLAG, 8'h02);
        wait_sig(4, 1'b0);
        sleep <= 1'b0;
        pin_dir <= 1'b0;
        wr_reg(ccpu_pkg::ADDR_CONTROL, 8'h8F);
        wr_reg(ccpu_pkg::ADDR_VAL_LOW, 8'h0A);
        base_run <= 1'b1;
        count_hi(h10);
        `CHK(h10 >= 10 && h10 <= 11, 1'b1)
        wr_reg(ccpu_pkg::ADDR_CONTROL, 8'h9F);
        wr_reg(ccpu_pkg::ADDR_VAL_LOW, 8'h00);
        wr_reg(ccpu_pkg::ADDR_VAL_HIGH, 8'h05);
        count_hi(h20);
        `CHK(h20 - h10, 10)
        wr_reg(ccpu_pkg::ADDR_VAL_HIGH, 8'h00);
        repeat (40) @(posedge clk);
        h0 = 0;
        repeat (32)
        begin
            @(posedge clk);
            #1;
            h0 += int'(uout);
        end
        `CHK(h0, 0)
        tally_and_finish();
    end
endmodule
